/* File: rtl/mcas_pkg.sv */
// shared constants and types for the modem call answer sequencer
package mcas_pkg;
    // clock and time base
    localparam int CLK_HZ = 250_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYC = CLK_HZ / MS_PER_S; // cycles per 1 ms tick
    localparam int BAUD_LO = 300;
    localparam int BAUD_HI = 1200;
    localparam int BIT_LO_CYC = CLK_HZ / BAUD_LO;
    localparam int BIT_HI_CYC = CLK_HZ / BAUD_HI;
    localparam int CW = 20; // cycle counter width
    localparam int MW = 16; // ms timer width
    // timeouts in ms
    localparam logic [MW-1:0] T_DTR_HOLD_MS = 16'h1388; // 5000 ms
    localparam logic [MW-1:0] T_ANSWER_MS = 16'h4E20; // 20000 ms
    localparam logic [MW-1:0] T_GLITCH_MS = 16'h01F4; // 500 ms
    localparam logic [MW-1:0] T_SPACE_MS = 16'h03E8; // 1000 ms
    localparam logic [MW-1:0] T_RECOVER_MS = 16'h07D0; // 2000 ms
    // synchronised input indices
    localparam int SIG_RI = 0;
    localparam int SIG_DSR = 1;
    localparam int SIG_CTS = 2;
    localparam int SIG_CD = 3;
    localparam int SIG_RXD = 4;
    localparam int SIG_KEY = 5;
    localparam int NSIG = 6;
    localparam logic [NSIG-1:0] SYNC_RST = 6'h10; // rxd idles at mark
    // serial framing
    localparam logic [3:0] FRAME_BITS = 4'hA; // start, 8 data, stop
    localparam logic [3:0] DATA_BITS = 4'h8;
    // register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TICK = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam int CTRL_BAUD_HI = 0;
    localparam logic CTRL_RST = 1'b0;
    // call states
    typedef enum logic [2:0] {
        ST_LOCAL,
        ST_IDLE,
        ST_WAIT_DSR,
        ST_WAIT_CAR,
        ST_WAIT_PKT,
        ST_CONN,
        ST_HOLD
    } mcas_state_t;
endpackage

/* File: rtl/mcas_top.sv */
// call answer and abort sequencer with serial framing toward an auto-answer modem
module mcas_top
    import mcas_pkg::*;
#(
    parameter int TICK_DEF = TICK_CYC, // cycles per ms tick after reset
    parameter int BIT_LO = BIT_LO_CYC, // bit period at low rate
    parameter int BIT_HI = BIT_HI_CYC // bit period at high rate
)
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, low active
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [3:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic key_remote, // keyswitch in either remote position
    input wire logic ri, // ring indicator from modem
    input wire logic dsr, // data set ready from modem
    input wire logic cts, // clear to send from modem
    input wire logic cd, // carrier detect from modem
    input wire logic rxd, // receive data from modem
    output logic dtr, // data terminal ready to modem
    output logic rts, // request to send to modem
    output logic txd, // transmit data to modem
    input wire logic [7:0] tx_data, // byte to send
    input wire logic tx_valid, // byte offered
    output logic tx_ready, // byte taken this cycle
    output logic [7:0] rx_data, // last received byte
    output logic rx_valid, // one-cycle pulse per good byte
    input wire logic pkt_ok, // upper layer saw a whole good packet
    output logic connected, // logical connection in effect
    output logic conn_lost // one-cycle pulse when termination starts
);
    typedef struct packed {
        mcas_state_t st; // call state
        logic [NSIG-1:0] s1; // sync stage one
        logic [NSIG-1:0] s2; // sync stage two
        logic [NSIG-1:0] s3; // sync stage three
        logic [NSIG-1:0] f; // accepted input levels
        logic baud_hi; // rate select
        logic [CW-1:0] tick_div; // cycles per ms tick, less one
        logic [CW-1:0] div; // tick prescaler
        logic [MW-1:0] t_ms; // time in state
        logic [MW-1:0] d_ms; // time since DSR seen
        logic [MW-1:0] drop_ms; // time a control line is missing
        logic [MW-1:0] space_ms; // time rxd sits at space
        logic cd_seen; // carrier seen this call
        logic dsr_seen; // DSR seen this call
        logic connected; // logical connection flag
        logic lost; // termination pulse
        logic dtr; // dtr drive
        logic rts; // rts drive
        logic [8:0] tx_sh; // outgoing bits after current
        logic [3:0] tx_bits; // bits left in frame
        logic [CW-1:0] tx_cnt; // bit timer
        logic txd; // line drive
        logic [7:0] rx_sh; // incoming bits
        logic [3:0] rx_bits; // bits sampled so far
        logic [CW-1:0] rx_cnt; // sample timer
        logic rx_busy; // frame in progress
        logic [7:0] rx_data; // captured byte
        logic rx_valid; // byte pulse
        logic [31:0] rdata; // bus read data
    } mcas_regs_t;

    mcas_regs_t r; // current state
    mcas_regs_t next_r; // next state

    // all four transmit qualifiers present
    function automatic logic lines_up(input logic d, input logic t, input logic [NSIG-1:0] s,
                                      input logic [3:0] dummy);
        lines_up = d & t & s[SIG_DSR] & s[SIG_CTS] & (dummy == 4'h0);
    endfunction

    // saturating ms increment
    function automatic logic [MW-1:0] ms_inc(input logic [MW-1:0] v, input logic tick);
        ms_inc = (tick && v != {MW{1'b1}}) ? v + 16'h0001 : v;
    endfunction

    logic tick; // one ms tick
    logic tx_ok; // transmit permitted
    logic term; // termination wanted
    logic car_up; // cd and cts both present
    logic [CW-1:0] bit_cyc; // selected bit period

    assign tick = (r.div == r.tick_div);
    assign tx_ok = lines_up(r.dtr, r.rts, r.f, 4'h0);
    assign car_up = r.f[SIG_CD] & r.f[SIG_CTS];
    assign bit_cyc = r.baud_hi ? CW'(BIT_HI) : CW'(BIT_LO);
    // a byte is taken only while the link may carry it
    assign tx_ready = tx_ok && r.tx_bits == 4'h0;

    // next-state logic
    always_comb
    begin
        next_r = r;
        next_r.lost = 1'b0;
        next_r.rx_valid = 1'b0;
        next_r.rdata = 32'h0000_0000;
        term = 1'b0;
        next_r.s1 = {key_remote, rxd, cd, cts, dsr, ri};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < NSIG; i++)
        begin
            // accept a level only once two late stages agree
            if (r.s2[i] == r.s3[i])
            begin
                next_r.f[i] = r.s3[i];
            end
        end
        next_r.div = tick ? '0 : r.div + 20'h00001;
        next_r.t_ms = ms_inc(r.t_ms, tick);
        next_r.d_ms = ms_inc(r.d_ms, tick);
        if (!r.f[SIG_DSR] || (r.st == ST_WAIT_PKT && !car_up))
        begin
            next_r.drop_ms = ms_inc(r.drop_ms, tick);
        end
        else
        begin
            next_r.drop_ms = '0;
        end
        next_r.space_ms = r.f[SIG_RXD] ? '0 : ms_inc(r.space_ms, tick);
        if (r.f[SIG_CD])
        begin
            next_r.cd_seen = 1'b1;
        end

        // call sequencer
        unique case (r.st)
            ST_LOCAL:
            begin
                // lines held low until a remote position
                next_r.dtr = 1'b0;
                next_r.rts = 1'b0;
                if (r.f[SIG_KEY])
                begin
                    next_r.st = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                next_r.dtr = 1'b0;
                next_r.rts = 1'b0;
                // wait for modem to clear DSR and CTS
                if (!r.f[SIG_DSR] && !r.f[SIG_CTS])
                begin
                    next_r.st = ST_WAIT_DSR;
                    next_r.dtr = 1'b1;
                    next_r.t_ms = '0;
                    next_r.cd_seen = 1'b0;
                    next_r.dsr_seen = 1'b0;
                end
            end
            ST_WAIT_DSR:
            begin
                if (r.f[SIG_DSR])
                begin
                    next_r.st = ST_WAIT_CAR;
                    next_r.rts = 1'b1;
                    next_r.dsr_seen = 1'b1;
                    next_r.t_ms = '0;
                    next_r.d_ms = '0;
                end
                else if (r.t_ms >= T_ANSWER_MS)
                begin
                    term = 1'b1;
                end
            end
            ST_WAIT_CAR:
            begin
                // carrier timeout after RTS; connection timeout
                // only long DSR drops count here
                if (r.t_ms >= T_ANSWER_MS || r.d_ms >= T_ANSWER_MS || r.drop_ms > T_GLITCH_MS)
                begin
                    term = 1'b1;
                end
                else if (car_up)
                begin
                    next_r.st = ST_WAIT_PKT;
                end
            end
            ST_WAIT_PKT:
            begin
                // first good packet opens the connection
                if (pkt_ok && car_up)
                begin
                    next_r.st = ST_CONN;
                    next_r.connected = 1'b1;
                end
                else if (r.d_ms >= T_ANSWER_MS || r.drop_ms > T_GLITCH_MS)
                begin
                    term = 1'b1;
                end
            end
            ST_CONN:
            begin
                // immediate loss or long space ends call
                // caller dropping carrier shows as CD loss
                if (!r.f[SIG_DSR] || !car_up || r.space_ms > T_SPACE_MS)
                begin
                    term = 1'b1;
                end
            end
            ST_HOLD:
            begin
                // two seconds with lines low before re-arming
                next_r.dtr = 1'b0;
                next_r.rts = 1'b0;
                if (r.t_ms >= T_RECOVER_MS)
                begin
                    next_r.st = ST_IDLE;
                end
            end
        endcase

        // local key starts termination at once
        // local key overrides the DTR hold
        if (!r.f[SIG_KEY] && r.st != ST_LOCAL)
        begin
            next_r.st = ST_LOCAL;
            next_r.dtr = 1'b0;
            next_r.rts = 1'b0;
            next_r.connected = 1'b0;
            next_r.lost = (r.st != ST_IDLE && r.st != ST_HOLD);
        end
        // DTR kept up 5 s after DSR unless carrier seen
        else if (term && (!r.dsr_seen || r.cd_seen || r.d_ms >= T_DTR_HOLD_MS))
        begin
            // drop lines, stop data, flag lost connection
            next_r.st = ST_HOLD;
            next_r.dtr = 1'b0;
            next_r.rts = 1'b0;
            next_r.t_ms = '0;
            next_r.lost = 1'b1;
            next_r.connected = 1'b0;
        end

        // transmit framing, only with all lines up
        if (!tx_ok)
        begin
            // aborting mid-frame is allowed; the far end sees a framing error
            next_r.tx_bits = '0;
            next_r.txd = 1'b1;
        end
        else if (r.tx_bits == 4'h0)
        begin
            next_r.txd = 1'b1;
            if (tx_valid)
            begin
                next_r.txd = 1'b0;
                next_r.tx_sh = {1'b1, tx_data};
                next_r.tx_bits = FRAME_BITS;
                next_r.tx_cnt = '0;
            end
        end
        else if (r.tx_cnt == bit_cyc)
        begin
            next_r.tx_cnt = '0;
            next_r.tx_bits = r.tx_bits - 4'h1;
            next_r.txd = (r.tx_bits == 4'h1) ? 1'b1 : r.tx_sh[0];
            next_r.tx_sh = {1'b1, r.tx_sh[8:1]};
        end
        else
        begin
            next_r.tx_cnt = r.tx_cnt + 20'h00001;
        end

        // receive framing; only while carrier and CTS present
        if (!car_up)
        begin
            next_r.rx_busy = 1'b0;
        end
        else if (!r.rx_busy)
        begin
            if (!r.f[SIG_RXD])
            begin
                // start edge; first sample lands mid start bit
                next_r.rx_busy = 1'b1;
                next_r.rx_cnt = bit_cyc >> 1;
                next_r.rx_bits = '0;
            end
        end
        else if (r.rx_cnt == '0)
        begin
            next_r.rx_cnt = bit_cyc;
            next_r.rx_bits = r.rx_bits + 4'h1;
            if (r.rx_bits == 4'h0 && r.f[SIG_RXD])
            begin
                // false start, back to hunting
                next_r.rx_busy = 1'b0;
            end
            else if (r.rx_bits > 4'h0 && r.rx_bits <= DATA_BITS)
            begin
                next_r.rx_sh = {r.f[SIG_RXD], r.rx_sh[7:1]};
            end
            else if (r.rx_bits > DATA_BITS)
            begin
                // stop bit must be mark, else the byte is dropped
                next_r.rx_busy = 1'b0;
                next_r.rx_valid = r.f[SIG_RXD];
                if (r.f[SIG_RXD])
                begin
                    next_r.rx_data = r.rx_sh;
                end
            end
        end
        else
        begin
            next_r.rx_cnt = r.rx_cnt - 20'h00001;
        end

        // register writes
        if (wr && addr == REG_CTRL)
        begin
            next_r.baud_hi = wdata[CTRL_BAUD_HI];
        end
        if (wr && addr == REG_TICK)
        begin
            next_r.tick_div = wdata[CW-1:0];
            next_r.div = '0;
        end
        // register reads, unmapped read as zero
        if (rd)
        begin
            unique case (addr)
                REG_CTRL: next_r.rdata = {31'h0000_0000, r.baud_hi};
                REG_TICK: next_r.rdata = {12'h000, r.tick_div};
                // exactly 32 bits: state, connected, dtr, rts, then the six filtered inputs
                REG_STAT: next_r.rdata = {20'h00000, r.st, r.connected, r.dtr, r.rts, r.f};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
            r.st <= ST_LOCAL;
            r.s1 <= SYNC_RST;
            r.s2 <= SYNC_RST;
            r.s3 <= SYNC_RST;
            r.f <= SYNC_RST;
            r.baud_hi <= CTRL_RST;
            r.tick_div <= CW'(TICK_DEF - 1);
            r.txd <= 1'b1;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign dtr = r.dtr;
    assign rts = r.rts;
    assign txd = r.txd;
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;
    assign connected = r.connected;
    assign conn_lost = r.lost;
endmodule

/* File: testbench/mcas_top_assertions.sv */
// port-level checks for the call answer sequencer
module mcas_top_assertions (
    input wire logic clk, // clock
    input wire logic rstn, // reset, low active
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata, // read data
    input wire logic key_remote, // keyswitch remote
    input wire logic dsr, // modem off hook
    input wire logic cts, // modem clear to send
    input wire logic dtr, // answer enable
    input wire logic rts, // carrier request
    input wire logic txd, // serial out
    input wire logic tx_valid, // byte offer
    input wire logic tx_ready, // byte taken
    input wire logic pkt_ok, // packet seen
    input wire logic connected, // link up
    input wire logic conn_lost // abort pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // abort flag stands one cycle only
    sequence abort_pulse;
        conn_lost ##1 !conn_lost;
    endsequence
    // both console lines released
    sequence lines_down;
        !dtr && !rts;
    endsequence
    a_abort_drops: assert property (conn_lost |-> lines_down ##0 !connected)
        else $error("abort left a line up");
    a_abort_once: assert property ($rose(conn_lost) |-> abort_pulse)
        else $error("abort flag too long");
    // local key holds lines low; slack covers input sync
    a_local_lines: assert property (!key_remote [*8] |-> lines_down)
        else $error("line up in local");
    // carrier request only with answer enable
    a_rts_dtr: assert property (rts |-> dtr)
        else $error("rts without dtr");
    // mark while a line is down
    a_tx_mark: assert property ((!dtr || !rts) [*2] |-> txd)
        else $error("txd active with lines down");
    a_tx_start: assert property (tx_valid && tx_ready |=> !txd)
        else $error("no start bit");
    a_conn_cause: assert property ($rose(connected) |-> $past(pkt_ok))
        else $error("connected without packet");
    a_conn_lines: assert property (connected |-> dtr && rts)
        else $error("connected with lines down");
    // answer enable only after modem cleared
    a_dtr_clear: assert property ($rose(dtr) |-> !$past(dsr, 5) && !$past(cts, 5))
        else $error("dtr raised while modem busy");
    // read data stands only after a read
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind mcas_top mcas_top_assertions mcas_top_assertions_inst (
    .clk(clk), .rstn(rstn), .rd(rd), .rdata(rdata), .key_remote(key_remote), .dsr(dsr), .cts(cts),
    .dtr(dtr), .rts(rts), .txd(txd), .tx_valid(tx_valid), .tx_ready(tx_ready), .pkt_ok(pkt_ok),
    .connected(connected), .conn_lost(conn_lost));

/* File: testbench/mcas_modem.sv */
// behavioural auto-answer modem behind the control lines
module mcas_modem #(
    parameter int ANS_DLY = 50, // ring cycles before off hook
    parameter int CTS_DLY = 700 // carrier to clear delay
)
(
    input wire logic clk, // clock
    input wire logic dtr, // answer enable
    input wire logic rts, // carrier request
    input wire logic ring, // caller rings
    input wire logic car, // caller carrier on line
    input wire logic cts_drop, // force clear to send low
    input wire logic space, // caller sends space
    input wire logic stuck, // keep lines after hang-up
    output logic ri, // ring indicator
    output logic dsr, // off hook
    output logic cts, // clear to send
    output logic cd, // carrier detect
    output logic rxd // receive data
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_ans; // ring age
    int n_cts; // carrier age
    logic cts_up; // clear to send before forcing
    // mark when idle or without carrier
    assign rxd = !(cd && space);
    assign cts = cts_up && !cts_drop;
    assign ri = ring && !dsr;
    initial
    begin
        {dsr, cd, cts_up} = 3'h0;
        {n_ans, n_cts} = 0;
    end
    // answer, carrier, then clear on hang-up
    always @(posedge clk)
    begin
        if (!dtr)
        begin
            // stuck models a faulty modem that keeps its lines
            n_ans <= 0;
            n_cts <= 0;
            dsr <= stuck && dsr;
            cts_up <= stuck && cts_up;
            cd <= 1'b0;
        end
        else
        begin
            if (ri)
                n_ans <= n_ans + 1;
            if (n_ans >= ANS_DLY)
                dsr <= 1'b1;
            cd <= dsr && rts && car;
            n_cts <= cd ? n_cts + 1 : 0;
            cts_up <= cd && n_cts >= CTS_DLY;
        end
    end
endmodule

/* File: testbench/mcas_top_tb_top.sv */
// self-checking bench for the call answer sequencer
module mcas_top_tb_top
    import mcas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] A_BAD = 4'hC; // unmapped address
    localparam logic [9:0] FRAME = 10'h34A; // stop, 8'hA5 lsb first, start
    localparam int W_DTR = 0;
    localparam int W_RTS = 1;
    localparam int W_CON = 2;
    localparam int W_LOST = 3;
    localparam int W_RXV = 4;
    logic clk = 1'b0; // 250 MHz
    logic rstn = 1'b0; // reset, low active
    logic [3:0] addr = 4'h0; // bus address
    logic [31:0] wdata = 32'h0; // bus write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic [31:0] rdata; // bus read data
    logic key_remote = 1'b0; // keyswitch
    logic ri, dsr, cts, cd, rxd; // modem lines
    logic dtr, rts, txd, tx_ready, connected, conn_lost; // design outputs
    logic ce = 1'b1; // clock enable
    logic [7:0] rx_data; // received byte
    logic rx_valid; // received byte pulse
    logic [7:0] tx_data = 8'hA5; // byte to send
    logic tx_valid = 1'b0; // byte offer
    logic pkt_ok = 1'b0; // packet seen upstream
    logic ring = 1'b0, car = 1'b0, cts_drop = 1'b0, space = 1'b0, stuck = 1'b0; // modem commands
    int fail_count = 0; // mismatches
    int cmp_count = 0; // comparisons
    int lost_cnt = 0; // abort pulses seen
    int n; // cycles waited

    initial
        forever #2 clk = ~clk;
    always @(posedge clk)
        if (conn_lost === 1'b1)
            lost_cnt <= lost_cnt + 1;

    // tick default 2 cycles; bench reprograms it to one cycle per ms
    mcas_top #(.TICK_DEF(2), .BIT_LO(16), .BIT_HI(8)) mcas_top_inst (
        .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .key_remote(key_remote), .ri(ri), .dsr(dsr), .cts(cts), .cd(cd), .rxd(rxd), .dtr(dtr), .rts(rts),
        .txd(txd), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid),
        .pkt_ok(pkt_ok), .connected(connected), .conn_lost(conn_lost));
    mcas_modem mcas_modem_inst (
        .clk(clk), .dtr(dtr), .rts(rts), .ring(ring), .car(car), .cts_drop(cts_drop), .space(space),
        .stuck(stuck), .ri(ri), .dsr(dsr), .cts(cts), .cd(cd), .rxd(rxd));

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, 32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("register", rdata, exp);
    endtask
    function automatic logic sig(input int w);
        case (w)
            W_DTR: return dtr;
            W_RTS: return rts;
            W_CON: return connected;
            W_RXV: return rx_valid;
            default: return conn_lost;
        endcase
    endfunction
    // bounded wait; n returns the cycles spent
    task automatic wait_sig(input int w, input logic v, input int lim);
        n = 0;
        while (sig(w) !== v && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("wait", 32'(sig(w)), 32'(v));
    endtask
    // ring, answer, caller carrier, then clear to send
    task automatic call_up;
        @(posedge clk);
        ring <= 1'b1;
        #1 wait_sig(W_RTS, 1'b1, 100);
        @(posedge clk);
        ring <= 1'b0;
        car <= 1'b1;
        repeat (800) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog well above the ~30k cycles of the sequence
    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1 check("dtr", dtr, 32'h0);
        check("txd", txd, 32'h1);
        rd_reg(REG_TICK, 32'h1);
        rd_reg(A_BAD, 32'h0);
        wr_reg(A_BAD, 32'hFFFFFFFF);
        wr_reg(REG_TICK, 32'h0);
        rd_reg(REG_TICK, 32'h0);
        rd_reg(REG_CTRL, 32'h0);
        // a write while the clock enable is low must be lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(REG_CTRL, 32'h1);
        ce <= 1'b1;
        rd_reg(REG_CTRL, 32'h0);
        // local state, lines low, only rxd at mark
        rd_reg(REG_STAT, 32'h0000_0010);
        #1 check("dtr", dtr, 32'h0);
        @(posedge clk);
        key_remote <= 1'b1;
        #1 wait_sig(W_DTR, 1'b1, 30);
        // unanswered call gives up, then recovers
        wait_sig(W_LOST, 1'b1, 20100);
        in_range("answer timeout", n, 19990, 20010);
        check("dtr", dtr, 32'h0);
        wait_sig(W_DTR, 1'b1, 2100);
        in_range("recovery", n, 1995, 2010);
        // short clear-to-send drop is ignored
        call_up();
        @(posedge clk);
        cts_drop <= 1'b1;
        repeat (100) @(posedge clk);
        cts_drop <= 1'b0;
        repeat (20) @(posedge clk);
        #1 check("aborts", lost_cnt, 32'h1);
        @(posedge clk);
        pkt_ok <= 1'b1;
        @(posedge clk);
        pkt_ok <= 1'b0;
        #1 wait_sig(W_CON, 1'b1, 10);
        // one frame, sampled mid-bit
        @(posedge clk);
        tx_valid <= 1'b1;
        #1;
        for (int i = 0; i < 50 && tx_ready !== 1'b1; i++)
            @(posedge clk) #1;
        @(posedge clk);
        tx_valid <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            #1 check("txd bit", txd, 32'(FRAME[i]));
            repeat (17) @(posedge clk);
        end
        // one frame in from the caller at the high rate, nine cycles a bit
        wr_reg(REG_CTRL, 32'h1);
        for (int i = 0; i < 9; i++)
        begin
            space <= ~FRAME[i];
            repeat (9) @(posedge clk);
        end
        space <= 1'b0;
        #1 wait_sig(W_RXV, 1'b1, 40);
        check("rx byte", rx_data, 32'h0000_00A5);
        // long space while connected
        @(posedge clk);
        space <= 1'b1;
        #1 wait_sig(W_LOST, 1'b1, 1100);
        in_range("space limit", n, 995, 1015);
        check("connected", connected, 32'h0);
        @(posedge clk);
        space <= 1'b0;
        car <= 1'b0;
        #1 wait_sig(W_DTR, 1'b1, 2100);
        // long drop, modem then refuses to clear
        call_up();
        @(posedge clk);
        cts_drop <= 1'b1;
        stuck <= 1'b1;
        #1 wait_sig(W_LOST, 1'b1, 700);
        in_range("drop limit", n, 500, 515);
        repeat (2500) @(posedge clk);
        #1 check("dtr", dtr, 32'h0);
        @(posedge clk);
        stuck <= 1'b0;
        cts_drop <= 1'b0;
        car <= 1'b0;
        #1 wait_sig(W_DTR, 1'b1, 50);
        // local key mid-answer
        @(posedge clk);
        ring <= 1'b1;
        #1 wait_sig(W_RTS, 1'b1, 100);
        @(posedge clk);
        key_remote <= 1'b0;
        #1 wait_sig(W_DTR, 1'b0, 20);
        check("rts", rts, 32'h0);
        repeat (100) @(posedge clk);
        #1 check("dtr", dtr, 32'h0);
        tally_and_finish();
    end
endmodule
